// ### inc/burst_pkg.sv
`default_nettype none
package burst_pkg;
  // ****************************************
  // data path and register map
  // ****************************************
  localparam int          DATA_W      = 32;
  localparam int          IDX_W       = 5;
  localparam int          REG_COUNT   = 32;
  localparam int          SW_ADDR_W   = 7;
  localparam logic [4:0]  CTL_ONE_IDX = 5'h00;
  localparam logic [4:0]  RELOAD_IDX  = 5'h0b;
  localparam logic [4:0]  REPEAT_IDX  = 5'h0c;
  localparam logic [4:0]  CMP_ONE_IDX = 5'h0d;
  localparam logic [4:0]  CONTROL_IDX = 5'h12;
  localparam logic [4:0]  WINDOW_IDX  = 5'h13;
  // ****************************************
  // burst control fields
  // ****************************************
  localparam int          CTRL_W      = 16;
  localparam int          BASE_LSB    = 0;
  localparam int          BEAT_LSB    = 8;
  localparam int          FIELD_W     = 5;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [31:0] REG_RESET   = 32'h0000_0000;
  // ****************************************
  // dma channel registers
  // ****************************************
  localparam int          H_ADDR_W    = 5;
  localparam logic [4:0]  H_CTRL      = 5'h00;
  localparam logic [4:0]  H_COUNT     = 5'h04;
  localparam logic [4:0]  H_MADDR     = 5'h08;
  localparam logic [4:0]  H_DATA      = 5'h0c;
  localparam logic [4:0]  H_STATUS    = 5'h10;
  localparam int          H_EN_BIT    = 0;
  localparam int          H_DIR_BIT   = 1;
  localparam int          COUNT_W     = 16;
  localparam int          FIFO_DEPTH  = 8;

  typedef enum logic [2:0] {
    B_IDLE = 3'b001,
    B_REQ  = 3'b010,
    B_NEXT = 3'b100
  } burst_state_t;

  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_XFER = 4'b0010,
    C_CAPT = 4'b0100,
    C_ACK  = 4'b1000
  } chan_state_t;
endpackage
`default_nettype wire

// ### inc/burst_if.sv
`timescale 1ns/100ps
`default_nettype none
interface burst_if;
  import burst_pkg::*;
  logic              dma_req;
  logic              dma_ack;
  logic              win_wr;
  logic              win_rd;
  logic [DATA_W-1:0] win_wdata;
  logic [DATA_W-1:0] win_rdata;

  modport timer_end (output dma_req, input dma_ack, input win_wr, input win_rd,
                     input win_wdata, output win_rdata);
  modport dma_end   (input dma_req, output dma_ack, output win_wr, output win_rd,
                     output win_wdata, input win_rdata);
endinterface
`default_nettype wire

// ### rtl/timer_dma_burst_redirect.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - one timer event becomes one or more DMA requests
// - window register stores nothing, forwards accesses
// - window reads and writes forwarded alike, except a window write never reaches the control register
// - target from control fields and pointer
// - beat-count field sets accesses per burst
// - base-index field picks first register index
// - base 0 is control one, 11 auto-reload
// - zero beats single request, else count+1
// - next request only after previous acknowledge
// - last acknowledge ends burst, ready again
// - successive accesses go to consecutive indices
// - pointer returns to base after burst
// - a new internal event repeats burst; several in one burst repeat it once
// - DMA keeps peripheral address on window
// - DMA increments memory address per transfer
// - DMA moves one element then acknowledges
// - enable DMA before the timer counter
// - same sequencing serves register read-out
module timer_dma_burst_redirect (
  input  wire logic                          clk_sys_i,
  input  wire logic                          srst_i,
  input  wire logic                          evt_req_i,
  input  wire logic [burst_pkg::SW_ADDR_W-1:0] reg_addr_i,
  input  wire logic [burst_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [burst_pkg::DATA_W-1:0]  reg_rdata_o,
  output logic                               burst_busy_o,
  burst_if.timer_end                         link
);
  import burst_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [DATA_W-1:0] timer_regs [REG_COUNT];
  logic [CTRL_W-1:0] burst_control_reg;
  logic [IDX_W-1:0]  ptr_reg;
  logic              pend_reg;
  logic              req_reg;
  logic [DATA_W-1:0] win_rdata_reg;
  logic [DATA_W-1:0] reg_rdata_reg;
  logic              busy_reg;
  burst_state_t      state_reg;
  burst_state_t      state_next;

  // ****************************************
  // decode
  // ****************************************
  wire logic [IDX_W-1:0] sw_idx          = reg_addr_i[SW_ADDR_W-1:2];
  wire logic [IDX_W-1:0] burst_base_index = burst_control_reg[BASE_LSB +: FIELD_W];
  wire logic [IDX_W-1:0] burst_beat_count = burst_control_reg[BEAT_LSB +: FIELD_W];
  // base plus pointer wraps inside the 32-entry map
  wire logic [IDX_W-1:0] target_idx      = burst_base_index + ptr_reg;
  wire logic             target_plain    = (target_idx != CONTROL_IDX) && (target_idx != WINDOW_IDX);
  wire logic             sw_ctrl_wr      = reg_wr_i && (sw_idx == CONTROL_IDX);
  wire logic             sw_win_wr       = reg_wr_i && (sw_idx == WINDOW_IDX);
  wire logic             sw_plain_wr     = reg_wr_i && !sw_ctrl_wr && !sw_win_wr;
  wire logic             sw_rd_win       = sw_idx == WINDOW_IDX;
  wire logic [IDX_W-1:0] sw_rd_idx       = sw_rd_win ? target_idx : sw_idx;
  wire logic             last_beat       = ptr_reg == burst_beat_count;
  wire logic             ack_in_req      = (state_reg == B_REQ) && link.dma_ack;
  wire logic             start_burst     = (state_reg == B_IDLE) && (evt_req_i || pend_reg) && !sw_ctrl_wr;
  // an event taken by the start itself is not held again
  wire logic             pend_set        = evt_req_i && !(start_burst && !pend_reg);
  wire logic             pend_keep       = pend_reg && !start_burst;

  // control and window own no array entry; their slots are never read back
  function automatic logic [DATA_W-1:0] read_value(input logic [IDX_W-1:0] idx);
    logic [DATA_W-1:0] v;
    v = timer_regs[idx];
    if (idx == CONTROL_IDX) begin
      v = {{(DATA_W-CTRL_W){1'b0}}, burst_control_reg};
    end else if (idx == WINDOW_IDX) begin
      v = {DATA_W{1'b0}};
    end
    return v;
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      B_IDLE: begin
        if (start_burst) begin
          state_next = B_REQ;
        end
      end
      B_REQ: begin
        if (sw_ctrl_wr) begin
          state_next = B_IDLE;
        end else if (link.dma_ack) begin
          state_next = last_beat ? B_IDLE : B_NEXT;
        end
      end
      B_NEXT: begin
        state_next = sw_ctrl_wr ? B_IDLE : B_REQ;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_reg <= B_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // busy follows the next state so it lines up with the state flop
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= state_next != B_IDLE;
    end
  end

  // request drops for one cycle between beats, so only one is ever open
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= state_next == B_REQ;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || sw_ctrl_wr) begin
      ptr_reg <= '0;
    end else if (ack_in_req) begin
      ptr_reg <= last_beat ? '0 : ptr_reg + 5'h01;
    end
  end

  // an event arriving mid-burst is held, and a new one beats the clear
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_set || pend_keep;
    end
  end

  // ****************************************
  // register storage and redirection
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      burst_control_reg <= CTRL_RESET;
    end else if (sw_ctrl_wr) begin
      burst_control_reg <= reg_wdata_i[CTRL_W-1:0];
    end
  end

  // dma write lands last, so it wins a same-cycle clash
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        timer_regs[i] <= REG_RESET;
      end
    end else begin
      if (sw_plain_wr) begin
        timer_regs[sw_idx] <= reg_wdata_i;
      end
      if (sw_win_wr && target_plain) begin
        timer_regs[target_idx] <= reg_wdata_i;
      end
      if (link.win_wr && target_plain) begin
        timer_regs[target_idx] <= link.win_wdata;
      end
    end
  end

  // window read answers in the next cycle, from the current target
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      win_rdata_reg <= '0;
    end else if (link.win_rd) begin
      win_rdata_reg <= read_value(target_idx);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_reg <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_reg <= read_value(sw_rd_idx);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.dma_req  = req_reg;
  assign link.win_rdata = win_rdata_reg;
  assign reg_rdata_o   = reg_rdata_reg;
  assign burst_busy_o  = busy_reg;
endmodule
`default_nettype wire

// ### rtl/dma_channel_end.sv
`timescale 1ns/100ps
`default_nettype none
module burst_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;

  wire logic full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire logic empty = wr_ptr_reg == rd_ptr_reg;
  wire logic push  = in_valid_i && !full;
  wire logic pop   = out_ready_i && !empty;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];
endmodule

module dma_channel_end (
  input  wire logic                           clk_sys_i,
  input  wire logic                           srst_i,
  input  wire logic [burst_pkg::H_ADDR_W-1:0] reg_addr_i,
  input  wire logic [burst_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output logic      [burst_pkg::DATA_W-1:0]   reg_rdata_o,
  output logic                                chan_busy_o,
  burst_if.dma_end                            link
);
  import burst_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic                 en_reg;
  logic                 p2m_reg;
  logic [COUNT_W-1:0]   count_reg;
  logic [DATA_W-1:0]    maddr_reg;
  logic                 ack_reg;
  logic                 win_wr_reg;
  logic                 win_rd_reg;
  logic [DATA_W-1:0]    win_wdata_reg;
  logic [DATA_W-1:0]    reg_rdata_reg;
  logic                 chan_busy_reg;
  chan_state_t          state_reg;
  chan_state_t          state_next;
  logic                 f_in_ready;
  logic                 f_out_valid;
  logic [DATA_W-1:0]    f_out_data;

  // ****************************************
  // decode
  // ****************************************
  wire logic sw_data_wr = reg_wr_i && (reg_addr_i == H_DATA);
  wire logic sw_data_rd = reg_rd_i && (reg_addr_i == H_DATA);
  // a pending request waits here until software enables the channel
  wire logic start      = (state_reg == C_IDLE) && en_reg && link.dma_req && (count_reg != '0) &&
                          (p2m_reg ? f_in_ready : f_out_valid);
  wire logic dma_pop    = start && !p2m_reg;
  wire logic f_in_valid = p2m_reg ? (state_reg == C_CAPT) : sw_data_wr;
  wire logic [DATA_W-1:0] f_in_data = p2m_reg ? link.win_rdata : reg_wdata_i;
  wire logic f_out_ready = p2m_reg ? sw_data_rd : dma_pop;
  wire logic [DATA_W-1:0] status_word = {{(DATA_W-3){1'b0}}, state_reg != C_IDLE, !f_in_ready, !f_out_valid};

  burst_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data)
  );

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      C_IDLE: state_next = start ? C_XFER : C_IDLE;
      C_XFER: state_next = p2m_reg ? C_CAPT : C_ACK;
      C_CAPT: state_next = C_ACK;
      C_ACK:  state_next = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_reg <= C_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      chan_busy_reg <= 1'b0;
    end else begin
      chan_busy_reg <= state_next != C_IDLE;
    end
  end

  // one element per request, always at the single window address
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      win_wr_reg <= 1'b0;
      win_rd_reg <= 1'b0;
    end else begin
      win_wr_reg <= dma_pop;
      win_rd_reg <= start && p2m_reg;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      win_wdata_reg <= '0;
    end else if (dma_pop) begin
      win_wdata_reg <= f_out_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= state_next == C_ACK;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      en_reg  <= 1'b0;
      p2m_reg <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == H_CTRL) begin
      en_reg  <= reg_wdata_i[H_EN_BIT];
      p2m_reg <= reg_wdata_i[H_DIR_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      count_reg <= '0;
      maddr_reg <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == H_COUNT) begin
        count_reg <= reg_wdata_i[COUNT_W-1:0];
      end else if (state_reg == C_ACK) begin
        count_reg <= count_reg - 1'b1;
      end
      if (reg_wr_i && reg_addr_i == H_MADDR) begin
        maddr_reg <= reg_wdata_i;
      end else if (state_reg == C_ACK) begin
        maddr_reg <= maddr_reg + 32'h0000_0004;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_reg <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        H_CTRL:   reg_rdata_reg <= {{(DATA_W-2){1'b0}}, p2m_reg, en_reg};
        H_COUNT:  reg_rdata_reg <= {{(DATA_W-COUNT_W){1'b0}}, count_reg};
        H_MADDR:  reg_rdata_reg <= maddr_reg;
        H_DATA:   reg_rdata_reg <= f_out_data;
        H_STATUS: reg_rdata_reg <= status_word;
        default:  reg_rdata_reg <= '0;
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.dma_ack   = ack_reg;
  assign link.win_wr    = win_wr_reg;
  assign link.win_rd    = win_rd_reg;
  assign link.win_wdata = win_wdata_reg;
  assign reg_rdata_o    = reg_rdata_reg;
  assign chan_busy_o    = chan_busy_reg;
endmodule
`default_nettype wire

// ### verif/burst_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module burst_link_props
  import burst_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              srst_i,
  input wire logic              dma_req,
  input wire logic              dma_ack,
  input wire logic              win_wr,
  input wire logic              win_rd,
  input wire logic [DATA_W-1:0] win_wdata,
  input wire logic [DATA_W-1:0] win_rdata
);
  // ****************************************
  // link handshake
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_access;
    win_wr || win_rd;
  endsequence

  // the channel must touch the window before it acknowledges
  sequence s_served;
    s_access ##[1:3] dma_ack;
  endsequence

  a_req_held: assert property (dma_req && !dma_ack |=> dma_req)
    else $error("request dropped without acknowledge");
  a_req_drop_ack: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("request still high after acknowledge");
  a_ack_needs_req: assert property (dma_ack |-> dma_req)
    else $error("acknowledge without request");
  a_ack_one_pulse: assert property (dma_ack |=> !dma_ack)
    else $error("acknowledge longer than one cycle");
  a_beat_served: assert property ($rose(dma_req) |-> ##[0:4] s_served)
    else $error("beat not served in time");
  a_access_in_beat: assert property (s_access |-> dma_req && !dma_ack)
    else $error("window access outside a beat");
  a_dir_exclusive: assert property (!(win_wr && win_rd))
    else $error("window read and write together");
  a_single_access: assert property (s_access |=> !(win_wr || win_rd) [*2])
    else $error("two window accesses in one beat");
  a_rdata_stands: assert property (!win_rd |=> $stable(win_rdata))
    else $error("window read data changed without read");
  a_wdata_stands: assert property (!win_wr |-> $stable(win_wdata))
    else $error("window write data changed outside a write");
endmodule
`default_nettype wire

// ### verif/tb_timer_dma_burst_redirect.sv
`timescale 1ns/100ps
`default_nettype none
module tb_timer_dma_burst_redirect;
  import burst_pkg::*;
  // ****************************************
  // stimulus table: base, beats, first word
  // ****************************************
  typedef struct packed {
    logic [4:0]  base;
    logic [4:0]  beats;
    logic [31:0] word0;
  } row_t;
  localparam row_t ROWS [4] = '{
    '{5'h0b, 5'h02, 32'h0000_0fa0},
    '{5'h00, 5'h00, 32'h0000_1230},
    '{5'h01, 5'h05, 32'h00a5_0000},
    '{5'h14, 5'h07, 32'h5a00_0010}
  };
  localparam logic [6:0] CTRL_A = {CONTROL_IDX, 2'b00};
  localparam logic [6:0] WIN_A  = {WINDOW_IDX, 2'b00};

  logic                 clk_sys_i = 1'b0;
  logic                 srst_i    = 1'b1;
  logic                 evt_req   = 1'b0;
  logic [SW_ADDR_W-1:0] d_addr    = 7'h00;
  logic [H_ADDR_W-1:0]  c_addr    = 5'h00;
  logic [31:0]          d_wdata   = 32'h0;
  logic [31:0]          c_wdata   = 32'h0;
  logic                 d_wr      = 1'b0;
  logic                 d_rd      = 1'b0;
  logic                 c_wr      = 1'b0;
  logic                 c_rd      = 1'b0;
  logic [31:0]          d_rdata;
  logic [31:0]          c_rdata;
  logic                 d_busy;
  logic                 c_busy;
  logic [31:0]          q;
  logic [31:0]          exp_reg [32];
  int                   n_mismatch = 0;
  int                   checked    = 0;
  int                   cyc        = 0;
  int                   n_ack      = 0;
  int                   ack_mark   = 0;

  burst_if link_if ();

  timer_dma_burst_redirect timer_dma_burst_redirect_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .evt_req_i(evt_req), .reg_addr_i(d_addr),
    .reg_wdata_i(d_wdata), .reg_wr_i(d_wr), .reg_rd_i(d_rd), .reg_rdata_o(d_rdata),
    .burst_busy_o(d_busy), .link(link_if));

  dma_channel_end dma_channel_end_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(c_addr), .reg_wdata_i(c_wdata),
    .reg_wr_i(c_wr), .reg_rd_i(c_rd), .reg_rdata_o(c_rdata), .chan_busy_o(c_busy),
    .link(link_if));

  burst_link_props burst_link_props_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .dma_req(link_if.dma_req),
    .dma_ack(link_if.dma_ack), .win_wr(link_if.win_wr), .win_rd(link_if.win_rd),
    .win_wdata(link_if.win_wdata), .win_rdata(link_if.win_rdata));

  always #5 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i) begin
    if (link_if.dma_req && link_if.dma_ack) n_ack++;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic end_of_test;
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] expect_v);
    checked++;
    if (seen !== expect_v) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expect_v);
    end
  endtask

  // both ports share address and data; only the strobe picks the end
  task automatic wr(input bit dev, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    d_addr  <= a;
    c_addr  <= a[4:0];
    d_wdata <= d;
    c_wdata <= d;
    d_wr    <= dev;
    c_wr    <= !dev;
    @(posedge clk_sys_i);
    d_wr    <= 1'b0;
    c_wr    <= 1'b0;
  endtask

  task automatic rd(input bit dev, input logic [6:0] a);
    @(posedge clk_sys_i);
    d_addr <= a;
    c_addr <= a[4:0];
    d_rd   <= dev;
    c_rd   <= !dev;
    @(posedge clk_sys_i);
    d_rd   <= 1'b0;
    c_rd   <= 1'b0;
    #1;
    q = dev ? d_rdata : c_rdata;
  endtask

  task automatic pulse_evt;
    @(posedge clk_sys_i);
    evt_req <= 1'b1;
    @(posedge clk_sys_i);
    evt_req <= 1'b0;
  endtask

  // busy is looked at mid-cycle, well away from the edge that moves it
  task automatic wait_idle;
    int i;
    i = 0;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    while ((d_busy || c_busy) && i < 300) begin
      @(negedge clk_sys_i);
      i++;
    end
    check({31'h0, d_busy}, 32'h0);
    check({31'h0, c_busy}, 32'h0);
  endtask

  // cfg=0 leaves control alone, so the pointer must already sit on base
  task automatic burst(input row_t r, input bit p2m, input bit cfg);
    int          k;
    int          n;
    int          acks;
    logic [4:0]  idx;
    n = int'(r.beats) + 1;
    if (cfg) wr(1, CTRL_A, {19'h0, r.beats, 3'h0, r.base});
    wr(0, 7'(H_COUNT), 32'(n));
    wr(0, 7'(H_MADDR), 32'h100);
    for (k = 0; k < n; k++) begin
      idx = r.base + 5'(k);
      if (!p2m) begin
        wr(0, 7'(H_DATA), r.word0 + 32'(k));
        exp_reg[idx] = r.word0 + 32'(k);
      end
    end
    if (!p2m && n == FIFO_DEPTH) begin
      rd(0, 7'(H_STATUS));
      check({31'h0, q[1]}, 32'h1);
      wr(0, 7'(H_DATA), 32'hdead_beef);
    end
    wr(0, 7'(H_CTRL), p2m ? 32'h3 : 32'h1);
    acks = n_ack;
    pulse_evt();
    wait_idle();
    check(32'(n_ack - acks), 32'(n));
    rd(0, 7'(H_MADDR));
    check(q, 32'h100 + 32'(4 * n));
    for (k = 0; k < n; k++) begin
      idx = r.base + 5'(k);
      rd(!p2m, p2m ? 7'(H_DATA) : {idx, 2'b00});
      check(q, exp_reg[idx]);
    end
    rd(0, 7'(H_STATUS));
    check({31'h0, q[0]}, 32'h1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    foreach (exp_reg[i]) exp_reg[i] = 32'h0;
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(1, CTRL_A);
    check(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      burst(ROWS[i], 1'b0, 1'b1);
    end
    burst('{5'h0b, 5'h01, 32'hc0de_0000}, 1'b0, 1'b1);
    burst('{5'h0b, 5'h01, 32'hc0de_0100}, 1'b0, 1'b0);
    burst('{5'h0b, 5'h02, 32'h0}, 1'b1, 1'b1);
    // awkward: an event inside a burst is held and replays the burst
    wr(0, 7'(H_CTRL), 32'h1);
    wr(0, 7'(H_COUNT), 32'h4);
    for (int k = 0; k < 4; k++) begin
      wr(0, 7'(H_DATA), 32'h2468_0000 + 32'(k));
    end
    wr(1, CTRL_A, 32'h0000_010b);
    ack_mark = n_ack;
    pulse_evt();
    pulse_evt();
    // the sequencer idles for one cycle between the two bursts
    wait_idle();
    wait_idle();
    check(32'(n_ack - ack_mark), 32'h4);
    rd(1, {REPEAT_IDX, 2'b00});
    check(q, 32'h2468_0003);
    // awkward: a control write in the gap between beats rewinds the pointer
    wr(0, 7'(H_COUNT), 32'h3);
    wr(0, 7'(H_DATA), 32'h2468_0010);
    wr(1, CTRL_A, 32'h0000_020b);
    ack_mark = n_ack;
    pulse_evt();
    repeat (2) @(posedge clk_sys_i);
    wr(1, CTRL_A, 32'h0000_0005);
    wait_idle();
    check(32'(n_ack - ack_mark), 32'h1);
    wr(1, WIN_A, 32'h1357_9bdf);
    rd(1, {5'h05, 2'b00});
    check(q, 32'h1357_9bdf);
    rd(1, WIN_A);
    check(q, 32'h1357_9bdf);
    rd(1, CTRL_A);
    check(q, 32'h0000_0005);
    end_of_test();
  end
endmodule
`default_nettype wire
